//--- core/dram_cfg_pkg.sv
package dram_cfg_pkg;
   // I/O ports of the index/data pair
   localparam logic [7:0] INDEX_PORT = 8'hEC;
   localparam logic [7:0] DATA_PORT = 8'hED;

   // Register indices
   localparam logic [7:0] IDX_SLOT = 8'h02;
   localparam logic [7:0] IDX_MAP = 8'h03;
   localparam logic [7:0] IDX_TIMING = 8'h05;
   localparam logic [7:0] IDX_REFRESH = 8'h06;

   // Values after reset, before straps load
   localparam logic [7:0] RST_SLOT = 8'hFF;
   localparam logic [7:0] RST_MAP = 8'h00;
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [7:0] RST_REFRESH = 8'h00;
   localparam logic [7:0] RST_INDEX = 8'h00;

   // Field positions
   localparam int MAP_WIDE = 7;
   localparam int MAP_REMAP = 4;
   localparam int TIM_WAKE = 7;
   localparam int TIM_DELAY = 6;
   localparam int TIM_FAST = 3;
   localparam int TIM_PAGE_MODE_DISABLE_N = 2;
   localparam int TIM_PAR = 1;
   localparam int TIM_ROW_STROBE_SHUTOFF = 0;
   localparam int REF_SUSP = 7;
   localparam int REF_CPUOFF = 6;
   localparam int REF_RESET_REQUEST_FLAG = 5;
   localparam int REF_HALT = 4;
   localparam logic [7:0] REF_SW_MASK = 8'hCF;

   // Slot pointer segment marks (A23-A16)
   localparam logic [7:0] SEG_MIN = 8'h04;
   localparam logic [7:0] SEG_640K = 8'h0A;
   localparam logic [7:0] SEG_1M = 8'h10;
   localparam logic [7:0] SEG_ROM = 8'hFE;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_STD_NS = 15625;
   localparam int REF_SLOW1_NS = 125000;
   localparam int REF_SLOW2_NS = 250000;
   localparam int REF_STD_CYCLES = REF_STD_NS / CLK_PERIOD_NS;
   localparam int REF_SLOW1_CYCLES = REF_SLOW1_NS / CLK_PERIOD_NS;
   localparam int REF_SLOW2_CYCLES = REF_SLOW2_NS / CLK_PERIOD_NS;
   localparam int CPU_RESET_NS = 160;
   localparam int CPU_RESET_CYCLES = (CPU_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_DELAY_CYCLES = 2;
   localparam int DOUBLE_RATE_CLOCK_PER_WAIT = 2;

   // Suspend sequencer
   typedef enum logic [1:0] {ST_RUN, ST_SUSPEND, ST_RESET} susp_state_e;

   // Decoded DRAM configuration
   typedef struct packed {
      logic wide_dram;
      logic [1:0] rom_move;
      logic remap_active;
      logic [3:0] map_select;
      logic [1:0] wait_states;
      logic [2:0] wait_double_rate_clock;
      logic [2:0] page_miss_waits;
      logic page_mode_off;
      logic parity_on;
      logic ras_shutoff;
   } dram_cfg_s;

   // Suspend and refresh controls
   typedef struct packed {
      logic suspended;
      logic slow_timebase;
      logic self_refresh;
      logic clocks_stopped;
      logic leakage_ctl;
      logic cpu_off_pins;
      logic ras_only;
      logic cas_before_ras;
      logic refresh_off;
   } power_s;
endpackage : dram_cfg_pkg

//--- core/dram_refresh_slot_config_regs.sv
`timescale 1ns/1ps
// What this block does
// - Wide-DRAM bit selects 512Kx8 parts, four banks up to 8 MB.
// - ROM-move bits relocate ROM ranges; loaded from straps 8 and 7.
// - Remap bit moves 384K to top only for 1-4 MB; strap 4.
// - Memory-map bits select the DRAM map; loaded from straps 3..0.
// - Wakeup and cache-enable bits choose shared pin role.
// - Writing one to cache-enable clears the wakeup bit.
// - Delay bit postpones cycle start two clocks on read misses.
// - Wait-state bits set DRAM wait states, two clocks each.
// - Page-miss waits follow wait bits and fast bit table.
// - Page-mode-disable bit turns page mode off; strap 6.
// - Parity-disable bit zero enables parity; resets to zero.
// - Shut-off bit keeps only one row strobe on bank miss.
// - Suspend enable with suspend input low enters suspend mode.
// - CPU-off option sets pin states and resets CPU on exit.
// - Reset-request flag sets on requests, cleared by CPU reset rise.
// - Halt flag sets on halt, clears on resets, NMI, acknowledge.
// - Refresh-mode field selects refresh type or disables it.
// - Refresh-period field gives 15.625, 125 or 250 us.
// - Slot pointer vs A23-A16 splits board memory and slot bus.
// - Pointer 00h disables bank selects for SRAM systems.
// - Pointer 04h-09h hides board DRAM from pointer to A0000h.
// - Pointer FEh or FFh gives no slot accesses; 0Ah-0Fh decode as 10h.
module dram_refresh_slot_config_regs #(
   parameter int REF_STD = dram_cfg_pkg::REF_STD_CYCLES,
   parameter int REF_SLOW1 = dram_cfg_pkg::REF_SLOW1_CYCLES,
   parameter int REF_SLOW2 = dram_cfg_pkg::REF_SLOW2_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Index/data I/O port
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // Strap pins and external pins
   input wire logic [8:0] strap_addr_lines,
   input wire logic suspend_n,
   input wire logic nmi,
   input wire logic rtc_32k,
   input wire logic miss_in,
   output logic wake_out,
   output logic wake_oe,
   // Sideband from the rest of the controller
   input wire logic [4:0] total_mem_mb,
   input wire logic cache_enable_bit,
   input wire logic cache_enable_wr,
   input wire logic dma_or_master,
   input wire logic kbd_reset_req,
   input wire logic porta_reset_req,
   input wire logic special_reset_req,
   input wire logic cpu_reset,
   input wire logic halt_cycle,
   input wire logic inta_cycle,
   // Cycle start
   input wire logic cycle_start_req,
   input wire logic read_miss,
   output logic cycle_start,
   // CPU address decode
   input wire logic mem_req,
   input wire logic [7:0] cpu_addr_hi,
   output logic board_sel,
   output logic slot_sel,
   output logic rom_sel,
   output logic bank_sel_en,
   // Configuration and power
   output dram_cfg_pkg::dram_cfg_s dram_cfg,
   output dram_cfg_pkg::power_s power,
   output logic refresh_tick,
   output logic miss_seen,
   output logic processor_reset_out,
   output logic coprocessor_reset_out
);
   logic [7:0] index_reg, index_next;
   logic [7:0] slot_reg, slot_next;
   logic [7:0] map_reg, map_next;
   logic [7:0] timing_reg, timing_next;
   logic [7:0] refresh_reg, refresh_next;
   logic [13:0] sync1_reg, sync2_reg;
   localparam int START_W = dram_cfg_pkg::START_DELAY_CYCLES + 1;

   logic rst_seen_reg, rtc_d_reg, nmi_d_reg, cpu_reset_d_reg;
   logic [START_W-1:0] start_pipe_reg;
   logic [17:0] ref_cnt_reg;
   logic [7:0] rst_cnt_reg;
   dram_cfg_pkg::susp_state_e state_reg, state_next;

   // Page-miss wait count from wait bits and fast bit
   function automatic logic [2:0] page_miss_ws(input logic [1:0] ws, input logic fast);
      logic [2:0] r;
      r = 3'h3;
      if (ws[1]) begin
         r = fast ? 3'h5 : 3'h4;
      end else if (!ws[0]) begin
         r = fast ? 3'h3 : 3'h2;
      end
      return r;
   endfunction : page_miss_ws

   // Refresh interval for the period field
   function automatic logic [17:0] ref_period(input logic [1:0] code);
      logic [17:0] r;
      r = 18'(REF_STD);
      case (code)
         2'h1: r = 18'(REF_SLOW1);
         2'h2: r = 18'(REF_SLOW2);
         default: r = 18'(REF_STD);
      endcase
      return r;
   endfunction : ref_period

   // Synchronised pins
   wire logic [8:0] strap_q = sync2_reg[8:0];
   wire logic susp_n_q = sync2_reg[9];
   wire logic nmi_q = sync2_reg[10];
   wire logic rtc_q = sync2_reg[11];
   wire logic miss_q = sync2_reg[12];

   // Port decode
   wire logic idx_wr = io_wr && io_addr == dram_cfg_pkg::INDEX_PORT;
   wire logic dat_wr = io_wr && io_addr == dram_cfg_pkg::DATA_PORT;
   wire logic dat_rd = io_rd && io_addr == dram_cfg_pkg::DATA_PORT;
   wire logic strap_load = !rst_seen_reg;
   wire logic wr_slot = dat_wr && index_reg == dram_cfg_pkg::IDX_SLOT;
   wire logic wr_map = dat_wr && index_reg == dram_cfg_pkg::IDX_MAP;
   wire logic wr_tim = dat_wr && index_reg == dram_cfg_pkg::IDX_TIMING;
   wire logic wr_ref = dat_wr && index_reg == dram_cfg_pkg::IDX_REFRESH;

   // Status events
   wire logic rst_req_set = kbd_reset_req || porta_reset_req || special_reset_req;
   wire logic cpu_reset_rise = cpu_reset && !cpu_reset_d_reg;
   wire logic halt_clr = cpu_reset || (nmi_q && !nmi_d_reg) || inta_cycle;
   wire logic rtc_rise = rtc_q && !rtc_d_reg;

   // Read mux, unmapped indices read zero
   wire logic [7:0] rd_mux =
      index_reg == dram_cfg_pkg::IDX_SLOT ? slot_reg :
      index_reg == dram_cfg_pkg::IDX_MAP ? map_reg :
      index_reg == dram_cfg_pkg::IDX_TIMING ? timing_reg :
      index_reg == dram_cfg_pkg::IDX_REFRESH ? refresh_reg : 8'h00;

   // Next values of the configuration registers
   assign index_next = idx_wr ? io_wdata : index_reg;
   assign slot_next = wr_slot ? io_wdata : slot_reg;
   assign map_next = strap_load ? {1'b0, strap_q[8:7], strap_q[4:0]} :
      wr_map ? io_wdata : map_reg;
   always_comb begin
      timing_next = timing_reg;
      if (strap_load) begin
         timing_next = {2'h0, strap_q[5], 2'h0, strap_q[6], 2'h0};
      end else if (wr_tim) begin
         timing_next = io_wdata;
      end
      if (cache_enable_wr && cache_enable_bit) begin
         timing_next[dram_cfg_pkg::TIM_WAKE] = 1'b0;
      end
   end

   // Refresh register: software bits plus two status flags
   always_comb begin
      refresh_next = refresh_reg;
      if (wr_ref) begin
         refresh_next = (io_wdata & dram_cfg_pkg::REF_SW_MASK) |
            (refresh_reg & ~dram_cfg_pkg::REF_SW_MASK);
      end
      if (rst_req_set) begin
         refresh_next[dram_cfg_pkg::REF_RESET_REQUEST_FLAG] = 1'b1;
      end
      if (cpu_reset_rise) begin
         refresh_next[dram_cfg_pkg::REF_RESET_REQUEST_FLAG] = 1'b0;
      end
      if (halt_clr) begin
         refresh_next[dram_cfg_pkg::REF_HALT] = 1'b0;
      end
      if (halt_cycle) begin
         refresh_next[dram_cfg_pkg::REF_HALT] = 1'b1;
      end
   end

   // Register storage; straps load on the first edge after release
   always_ff @(posedge clk) begin
      if (!nrst) begin
         index_reg <= dram_cfg_pkg::RST_INDEX;
         slot_reg <= dram_cfg_pkg::RST_SLOT;
         map_reg <= dram_cfg_pkg::RST_MAP;
         timing_reg <= dram_cfg_pkg::RST_TIMING;
         refresh_reg <= dram_cfg_pkg::RST_REFRESH;
         rst_seen_reg <= 1'b0;
      end else begin
         index_reg <= index_next;
         slot_reg <= slot_next;
         map_reg <= map_next;
         timing_reg <= timing_next;
         refresh_reg <= refresh_next;
         rst_seen_reg <= 1'b1;
      end
   end

   // Pin synchronisers run through reset, so straps are settled at release
   always_ff @(posedge clk) begin
      sync1_reg <= {1'b1, miss_in, rtc_32k, nmi, suspend_n, strap_addr_lines};
      sync2_reg <= sync1_reg;
      rtc_d_reg <= rtc_q; // Tracks the pin in reset: no false edge
      nmi_d_reg <= nmi_q;
      if (!nrst) begin
         cpu_reset_d_reg <= 1'b0;
      end else begin
         cpu_reset_d_reg <= cpu_reset;
      end
   end

   // Read data, wake pin and miss input
   wire logic wake_mode = timing_reg[dram_cfg_pkg::TIM_WAKE] && !cache_enable_bit;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         io_rdata <= 8'h00;
         wake_out <= 1'b0;
         wake_oe <= 1'b0;
         miss_seen <= 1'b0;
      end else begin
         io_rdata <= dat_rd ? rd_mux : 8'h00;
         wake_oe <= wake_mode;
         wake_out <= !dma_or_master;
         miss_seen <= cache_enable_bit && !miss_q;
      end
   end

   // Cycle start, postponed on read misses when delay is set
   wire logic delay_it = timing_reg[dram_cfg_pkg::TIM_DELAY] && read_miss;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         start_pipe_reg <= '0;
         cycle_start <= 1'b0;
      end else begin
         start_pipe_reg <= {start_pipe_reg[START_W-2:0], cycle_start_req && delay_it};
         cycle_start <= (cycle_start_req && !delay_it) || start_pipe_reg[START_W-2];
      end
   end

   // Decoded DRAM configuration
   wire logic remap_ok = total_mem_mb >= 5'h01 && total_mem_mb <= 5'h04;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dram_cfg <= '0;
      end else begin
         dram_cfg.wide_dram <= map_reg[dram_cfg_pkg::MAP_WIDE];
         dram_cfg.rom_move <= map_reg[6:5];
         dram_cfg.remap_active <= map_reg[dram_cfg_pkg::MAP_REMAP] && remap_ok;
         dram_cfg.map_select <= map_reg[3:0];
         dram_cfg.wait_states <= timing_reg[5:4];
         dram_cfg.wait_double_rate_clock <= 3'({1'b0, timing_reg[5:4]} * 3'(dram_cfg_pkg::DOUBLE_RATE_CLOCK_PER_WAIT));
         dram_cfg.page_miss_waits <= page_miss_ws(timing_reg[5:4],
            timing_reg[dram_cfg_pkg::TIM_FAST]);
         dram_cfg.page_mode_off <= timing_reg[dram_cfg_pkg::TIM_PAGE_MODE_DISABLE_N];
         dram_cfg.parity_on <= !timing_reg[dram_cfg_pkg::TIM_PAR];
         dram_cfg.ras_shutoff <= timing_reg[dram_cfg_pkg::TIM_ROW_STROBE_SHUTOFF];
      end
   end

   // Suspend sequencer
   wire logic susp_req = refresh_reg[dram_cfg_pkg::REF_SUSP] && !susp_n_q;
   wire logic cpu_off = refresh_reg[dram_cfg_pkg::REF_CPUOFF];
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dram_cfg_pkg::ST_RUN: begin
            if (susp_req) begin
               state_next = dram_cfg_pkg::ST_SUSPEND;
            end
         end
         dram_cfg_pkg::ST_SUSPEND: begin
            if (!susp_req) begin
               state_next = cpu_off ? dram_cfg_pkg::ST_RESET : dram_cfg_pkg::ST_RUN;
            end
         end
         dram_cfg_pkg::ST_RESET: begin
            if (rst_cnt_reg == 8'h01) begin
               state_next = dram_cfg_pkg::ST_RUN;
            end
         end
         default: state_next = dram_cfg_pkg::ST_RUN;
      endcase
   end

   // Sequencer state, reset pulse length and reset outputs
   wire logic enter_reset = state_reg == dram_cfg_pkg::ST_SUSPEND &&
      state_next == dram_cfg_pkg::ST_RESET;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= dram_cfg_pkg::ST_RUN;
         rst_cnt_reg <= 8'h00;
         processor_reset_out <= 1'b0;
         coprocessor_reset_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         rst_cnt_reg <= enter_reset ? 8'(dram_cfg_pkg::CPU_RESET_CYCLES) :
            rst_cnt_reg - 8'(rst_cnt_reg != 8'h00);
         processor_reset_out <= state_next == dram_cfg_pkg::ST_RESET;
         coprocessor_reset_out <= state_next == dram_cfg_pkg::ST_RESET;
      end
   end

   // Power and refresh controls
   wire logic in_susp = state_reg == dram_cfg_pkg::ST_SUSPEND;
   wire logic [1:0] rmode = refresh_reg[3:2];
   always_ff @(posedge clk) begin
      if (!nrst) begin
         power <= '0;
      end else begin
         power.suspended <= in_susp;
         power.slow_timebase <= in_susp;
         power.self_refresh <= in_susp && rmode == 2'h2;
         power.clocks_stopped <= in_susp;
         power.leakage_ctl <= in_susp;
         power.cpu_off_pins <= in_susp && cpu_off;
         power.ras_only <= rmode == 2'h0;
         power.cas_before_ras <= rmode == 2'h1 || (rmode == 2'h2 && !in_susp);
         power.refresh_off <= rmode == 2'h3;
      end
   end

   // Refresh request timer; suspend counts 32 kHz edges instead
   wire logic ref_step = in_susp ? rtc_rise : 1'b1;
   wire logic ref_done = ref_step && ref_cnt_reg >= ref_period(refresh_reg[1:0]) - 18'h1;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ref_cnt_reg <= 18'h0;
         refresh_tick <= 1'b0;
      end else begin
         ref_cnt_reg <= ref_done ? 18'h0 : ref_cnt_reg + 18'(ref_step);
         refresh_tick <= ref_done && rmode != 2'h3;
      end
   end

   // Slot pointer decode
   wire logic [7:0] eff_ptr = (slot_reg >= dram_cfg_pkg::SEG_640K &&
      slot_reg < dram_cfg_pkg::SEG_1M) ? dram_cfg_pkg::SEG_1M : slot_reg;
   wire logic low_ptr = slot_reg < dram_cfg_pkg::SEG_640K;
   wire logic in_rom = cpu_addr_hi >= dram_cfg_pkg::SEG_ROM;
   wire logic in_hole = cpu_addr_hi >= dram_cfg_pkg::SEG_640K &&
      cpu_addr_hi < dram_cfg_pkg::SEG_1M;
   wire logic in_base = cpu_addr_hi < dram_cfg_pkg::SEG_640K;
   wire logic ptr_on = slot_reg != 8'h00;
   wire logic below_ptr = cpu_addr_hi < eff_ptr;
   wire logic want_board = ptr_on && !in_hole && !in_rom &&
      (low_ptr ? below_ptr : (in_base || below_ptr));
   wire logic want_slot = ptr_on && !in_hole && !in_rom && !want_board;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         board_sel <= 1'b0;
         slot_sel <= 1'b0;
         rom_sel <= 1'b0;
         bank_sel_en <= 1'b0;
      end else begin
         board_sel <= mem_req && want_board;
         slot_sel <= mem_req && want_slot;
         rom_sel <= mem_req && in_rom;
         bank_sel_en <= ptr_on;
      end
   end

   // Straps appear in the map register after release
   strap_load_a: assert property (@(posedge clk) disable iff (!nrst)
      strap_load |=> map_reg[3:0] == $past(strap_q[3:0]) && map_reg[6:5] == $past(strap_q[8:7]))
      else $error("straps not loaded");

   // Cache-enable write clears wakeup
   cache_clr_a: assert property (@(posedge clk) disable iff (!nrst)
      cache_enable_wr && cache_enable_bit |=> !timing_reg[dram_cfg_pkg::TIM_WAKE])
      else $error("wakeup not cleared");

   // Delayed start arrives three edges later
   start_delay_a: assert property (@(posedge clk) disable iff (!nrst)
      cycle_start_req && delay_it && !$past(cycle_start_req) |=> !cycle_start ##2 cycle_start)
      else $error("start delay wrong");

   // Page-miss wait count
   page_miss_a: assert property (@(posedge clk) disable iff (!nrst)
      timing_reg[5:4] == 2'h3 && timing_reg[3] ##1 $stable(timing_reg)
      |-> dram_cfg.page_miss_waits == 3'h5)
      else $error("page miss waits wrong");

   // Reset-request flag cleared by CPU reset rise
   reset_request_flag_clr_a: assert property (@(posedge clk) disable iff (!nrst)
      cpu_reset_rise |=> !refresh_reg[dram_cfg_pkg::REF_RESET_REQUEST_FLAG])
      else $error("reset request not cleared");

   // Halt flag set by halt cycle
   halt_set_a: assert property (@(posedge clk) disable iff (!nrst)
      halt_cycle |=> refresh_reg[dram_cfg_pkg::REF_HALT])
      else $error("halt flag not set");

   // Zero pointer keeps DRAM selects off
   slot_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      slot_reg == 8'h00 && $stable(slot_reg) |=> !bank_sel_en && !board_sel)
      else $error("dram selected with zero pointer");

   // Top segments never go to the slots
   rom_seg_a: assert property (@(posedge clk) disable iff (!nrst)
      mem_req && cpu_addr_hi >= dram_cfg_pkg::SEG_ROM |=> rom_sel && !slot_sel)
      else $error("top segment reached slots");

   // Exit with CPU-off raises both resets
   susp_reset_a: assert property (@(posedge clk) disable iff (!nrst)
      enter_reset |=> processor_reset_out && coprocessor_reset_out)
      else $error("no reset on suspend exit");
endmodule : dram_refresh_slot_config_regs

//--- test/cpu_bus_model.sv
`timescale 1ns/1ps
// Processor side: cycle start requests and memory addresses
module cpu_bus_model (
   // Clock
   input wire logic clk,
   // Bus outputs
   output logic start_req = 1'b0,
   output logic miss = 1'b0,
   output logic req = 1'b0,
   output logic [7:0] addr = 8'h00
);
   // One start pulse; the miss line shows the inverse once released
   task automatic start(input logic m);
      @(negedge clk);
      start_req = 1'b1;
      miss = m;
      @(negedge clk);
      start_req = 1'b0;
      miss = ~m;
   endtask : start

   // Present a memory address and hold it
   task automatic access(input logic [7:0] a);
      @(negedge clk);
      req = 1'b1;
      addr = a;
   endtask : access
endmodule : cpu_bus_model

//--- test/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the configuration register block
module testbench;
   localparam logic [7:0] IP = dram_cfg_pkg::INDEX_PORT;
   localparam logic [7:0] DP = dram_cfg_pkg::DATA_PORT;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_addr = 8'h00;
   logic [7:0] io_wdata = 8'h00;
   logic [8:0] straps = 9'h000;
   logic cen = 1'b0;
   logic cen_wr = 1'b0;
   logic dma = 1'b0;
   logic kbd = 1'b0;
   logic cpu_rst = 1'b0;
   logic halt = 1'b0;
   logic inta = 1'b0;
   logic porta = 1'b0;
   logic special = 1'b0;
   logic nmi = 1'b0;
   logic susp_n = 1'b1;
   logic miss_pin = 1'b1;
   logic [4:0] total_mb = 5'h02;
   logic miss_sn, cpu_rst_out, npx_rst_out;
   dram_cfg_pkg::power_s pwr;
   logic rd_flag = 1'b0;
   logic [7:0] io_rdata;
   logic [7:0] addr_hi;
   logic start_req, miss, req, wake_out, wake_oe, cyc_start;
   logic board_sel, slot_sel, rom_sel, bank_sel_en, tick;
   dram_cfg_pkg::dram_cfg_s cfg;
   logic [7:0] notes[$];
   int errors = 0;
   int comparisons = 0;
   int n;
   logic [7:0] v;
   logic [7:0] p;

   always #5 clk = ~clk;

   dram_refresh_slot_config_regs #(.REF_STD(20), .REF_SLOW1(40), .REF_SLOW2(60))
      dram_refresh_slot_config_regs_inst (
      .clk(clk), .nrst(nrst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .strap_addr_lines(straps),
      .suspend_n(susp_n), .nmi(nmi), .rtc_32k(1'b0), .miss_in(miss_pin),
      .wake_out(wake_out), .wake_oe(wake_oe), .total_mem_mb(total_mb),
      .cache_enable_bit(cen), .cache_enable_wr(cen_wr), .dma_or_master(dma),
      .kbd_reset_req(kbd), .porta_reset_req(porta), .special_reset_req(special),
      .cpu_reset(cpu_rst), .halt_cycle(halt), .inta_cycle(inta),
      .cycle_start_req(start_req), .read_miss(miss), .cycle_start(cyc_start),
      .mem_req(req), .cpu_addr_hi(addr_hi), .board_sel(board_sel),
      .slot_sel(slot_sel), .rom_sel(rom_sel), .bank_sel_en(bank_sel_en),
      .dram_cfg(cfg), .power(pwr), .refresh_tick(tick), .miss_seen(miss_sn),
      .processor_reset_out(cpu_rst_out), .coprocessor_reset_out(npx_rst_out));

   cpu_bus_model cpu_bus_model_inst (
      .clk(clk), .start_req(start_req), .miss(miss), .req(req), .addr(addr_hi));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict;
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Bus cycles: signals change at the falling edge
   task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      io_wr = w;
      io_rd = r;
      io_addr = a;
      io_wdata = d;
   endtask : cyc

   task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
      cyc(1'b1, 1'b0, IP, i);
      cyc(1'b1, 1'b0, DP, d);
      cyc(1'b0, 1'b0, IP, 8'h00);
      repeat (2) @(negedge clk);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] i, input logic [7:0] e);
      cyc(1'b1, 1'b0, IP, i);
      cyc(1'b0, 1'b1, DP, 8'h00);
      notes.push_back(e);
      cyc(1'b0, 1'b0, IP, 8'h00);
   endtask : rd_reg

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   // Address decode seen two edges after the address is presented
   task automatic dec(input logic [7:0] a, input logic [2:0] e);
      cpu_bus_model_inst.access(a);
      repeat (2) @(negedge clk);
      check({5'h00, board_sel, slot_sel, rom_sel}, {5'h00, e});
   endtask : dec

   // Read data checker: oldest note against the cycle after the strobe
   always @(posedge clk) rd_flag <= io_rd && io_addr === DP;
   always @(negedge clk) if (rd_flag) check(io_rdata, notes.pop_front());

   // Watchdog against a hung run
   initial begin
      #300000;
      errors++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h5A205E8F));
      straps = 9'($urandom);
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      check(8'(cfg.parity_on), 8'h01);
      rd_reg(dram_cfg_pkg::IDX_MAP, {1'b0, straps[8:7], straps[4:0]});
      rd_reg(dram_cfg_pkg::IDX_TIMING, {2'h0, straps[5], 2'h0, straps[6], 2'h0});
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h00);
      rd_reg(8'h04, 8'h00);
      v = 8'($urandom);
      wr_reg(dram_cfg_pkg::IDX_MAP, v);
      check({cfg.wide_dram, cfg.rom_move, cfg.remap_active, cfg.map_select}, v);
      // Remap has no effect outside 1-4 MB of total memory
      total_mb = 5'h06;
      wr_reg(dram_cfg_pkg::IDX_MAP, v | 8'h10);
      check(8'(cfg.remap_active), 8'h00);
      wr_reg(dram_cfg_pkg::IDX_REFRESH, 8'h3E);
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h0E);
      // Refresh period per code
      for (int c = 0; c < 3; c++) begin
         wr_reg(dram_cfg_pkg::IDX_REFRESH, 8'(c));
         n = 0;
         while (tick !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
         end
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (tick !== 1'b1 && n < 200);
         check(8'(n), 8'(20 * (c + 1)));
      end
      // Wait-state table over all codes
      for (int t = 0; t < 8; t++) begin
         wr_reg(dram_cfg_pkg::IDX_TIMING, 8'(t << 3));
         n = (t[2:1] == 0) ? 2 + t[0] : (t[2:1] == 1) ? 3 : 4 + t[0];
         check(8'(cfg.page_miss_waits), 8'(n));
         check({cfg.wait_states, 3'h0, cfg.wait_double_rate_clock}, {t[2:1], 3'h0, t[2:1], 1'b0});
      end
      wr_reg(dram_cfg_pkg::IDX_TIMING, 8'h87);
      check({5'h00, cfg.page_mode_off, cfg.parity_on, cfg.ras_shutoff}, 8'h05);
      check({6'h00, wake_oe, wake_out}, 8'h03);
      dma = 1'b1;
      repeat (2) @(negedge clk);
      check(8'(wake_out), 8'h00);
      dma = 1'b0;
      cen = 1'b1;
      pulse(cen_wr);
      rd_reg(dram_cfg_pkg::IDX_TIMING, 8'h07);
      // Cache mode: the shared pin is the low-active miss input
      miss_pin = 1'b0;
      repeat (4) @(negedge clk);
      check(8'(miss_sn), 8'h01);
      miss_pin = 1'b1;
      // Cycle start with and without a read miss
      wr_reg(dram_cfg_pkg::IDX_TIMING, 8'h40);
      for (int m = 0; m < 2; m++) begin
         cpu_bus_model_inst.start(m[0]);
         n = 1;
         while (cyc_start !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
         end
         check(8'(n), m ? 8'h03 : 8'h01);
      end
      // Status flags set and cleared
      pulse(kbd);
      pulse(halt);
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h32);
      pulse(inta);
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h22);
      pulse(cpu_rst);
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h02);
      pulse(porta);
      pulse(halt);
      nmi = 1'b1;
      repeat (4) @(negedge clk);
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h22);
      pulse(cpu_rst);
      pulse(special);
      rd_reg(dram_cfg_pkg::IDX_REFRESH, 8'h22);
      // Suspend with the CPU-off option, then the reset pulse on exit
      wr_reg(dram_cfg_pkg::IDX_REFRESH, 8'hC8);
      susp_n = 1'b0;
      repeat (5) @(negedge clk);
      v = {4'h0, pwr.suspended, pwr.self_refresh, pwr.cpu_off_pins, pwr.cas_before_ras};
      check(v, 8'h0E);
      susp_n = 1'b1;
      repeat (3) @(negedge clk);
      n = 0;
      while (cpu_rst_out === 1'b1 && npx_rst_out === 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check(8'(n), 8'(dram_cfg_pkg::CPU_RESET_CYCLES));
      // Slot pointer decode; values 01h-03h are never programmed
      p = 8'h11 + 8'($urandom % 237);
      wr_reg(dram_cfg_pkg::IDX_SLOT, p);
      rd_reg(dram_cfg_pkg::IDX_SLOT, p);
      dec(p - 8'h01, 3'b100);
      dec(p, 3'b010);
      dec(8'hFE, 3'b001);
      wr_reg(dram_cfg_pkg::IDX_SLOT, 8'hFF);
      dec(8'hFD, 3'b100);
      wr_reg(dram_cfg_pkg::IDX_SLOT, 8'h06);
      dec(8'h08, 3'b010);
      wr_reg(dram_cfg_pkg::IDX_SLOT, 8'h00);
      check(8'(bank_sel_en), 8'h00);
      repeat (2) @(negedge clk);
      print_verdict();
   end
endmodule : testbench
